// File: logic/block_memory_params.svh
// Constants for the embedded block memory with FIFO control.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BLOCK_MEMORY_PARAMS_SVH
`define BLOCK_MEMORY_PARAMS_SVH

// ---------------------------------------------------------------
// Array geometry
// ---------------------------------------------------------------
`define BM_MEM_BITS    9216
`define BM_DATA_W      18
`define BM_ADDR_W      13
`define BM_PTR_W       14
`define BM_WIDTH_W     5
`define BM_CS_W        3

// ---------------------------------------------------------------
// Buffer geometry
// ---------------------------------------------------------------
`define BM_BUF_DEPTH   2
`define BM_BUF_IDX_W   1
`define BM_BUF_CNT_W   2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BM_DATA_RESET  18'h00000
`define BM_PTR_RESET   14'h0000
`define BM_CNT_RESET   2'h0
`define BM_INIT_RESET  {`BM_MEM_BITS{1'b0}}

`endif

// File: logic/block_memory_pkg.sv
// Types shared by the block memory core and its read buffer.
// Assumes the constants header is on the include path.
`include "block_memory_params.svh"

package block_memory_pkg;

  // ---------------------------------------------------------------
  // Modes and shapes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_single,
    mode_true_dual,
    mode_pseudo_dual,
    mode_fifo
  } mem_mode_t;

  typedef enum logic [2:0] {
    shape_8192x1,
    shape_4096x2,
    shape_2048x4,
    shape_1024x9,
    shape_512x18
  } shape_t;

  typedef enum logic [1:0] {
    wm_normal,
    wm_write_through,
    wm_read_before_write
  } write_mode_t;

  // ---------------------------------------------------------------
  // Carriers and state
  // ---------------------------------------------------------------
  typedef struct packed {
    shape_t      shape;
    write_mode_t write_mode;
    logic        out_reg_en;
  } port_cfg_t;

  typedef struct packed {
    logic                  valid;
    logic                  we;
    logic [`BM_PTR_W-1:0]  bit_addr;
    logic [`BM_DATA_W-1:0] data;
  } port_req_t;

  typedef struct packed {
    port_req_t             req_a;
    port_req_t             req_b;
    logic [`BM_DATA_W-1:0] latch_a;
    logic [`BM_DATA_W-1:0] latch_b;
    logic [`BM_DATA_W-1:0] oreg_a;
    logic [`BM_DATA_W-1:0] oreg_b;
    logic [`BM_PTR_W-1:0]  wptr;
    logic                  full;
    logic                  almost_full;
    logic                  empty;
    logic                  almost_empty;
    logic                  push_pending;
  } core_state_t;

  typedef struct packed {
    logic [`BM_BUF_DEPTH-1:0][`BM_DATA_W-1:0] slot;
    logic [`BM_BUF_IDX_W-1:0]                 rd_idx;
    logic [`BM_BUF_IDX_W-1:0]                 wr_idx;
    logic [`BM_BUF_CNT_W-1:0]                 count;
  } buf_state_t;

endpackage

// File: logic/read_stall_buffer.sv
// Two-entry buffer on the FIFO read data stream.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "block_memory_params.svh"

module read_stall_buffer
  import block_memory_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     in_valid,
  input  wire logic [`BM_DATA_W-1:0]    in_data,
  output logic                          in_ready,
  output logic                          out_valid,
  output logic [`BM_DATA_W-1:0]         out_data,
  input  wire logic                     out_ready,
  output logic [`BM_BUF_CNT_W-1:0]      count
);

  buf_state_t s;
  buf_state_t next_s;
  logic       push;
  logic       pop;

  // ---------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------
  // Full and empty follow the entry count.
  assign in_ready  = s.count != `BM_BUF_CNT_W'(`BM_BUF_DEPTH);
  assign out_valid = s.count != `BM_CNT_RESET;
  assign out_data  = s.slot[s.rd_idx];
  assign count     = s.count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Slot storage and pointer movement.
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.slot[s.wr_idx] = in_data;
      next_s.wr_idx         = s.wr_idx + 1'b1;
    end
    if (pop) begin
      next_s.rd_idx = s.rd_idx + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

`default_nettype wire

// File: logic/embedded_block_ram_fifo.sv
// Embedded 9-kbit block memory: RAM, ROM and FIFO modes on one array.
// Assumes user logic on mclk drives every port; write and read clocks
// of the FIFO are both mclk in this build.
`timescale 1ns/1ps
`default_nettype none
`include "block_memory_params.svh"

module embedded_block_ram_fifo
  import block_memory_pkg::*;
#(
  parameter logic [`BM_MEM_BITS-1:0] INIT_CONTENTS = `BM_INIT_RESET
)
(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     global_set_reset_n,
  input  wire logic                     read_pointer_reset,
  input  wire mem_mode_t                memory_mode,
  input  wire port_cfg_t                port_a_cfg,
  input  wire port_cfg_t                port_b_cfg,
  input  wire logic                     output_reset_async,
  input  wire logic [`BM_CS_W-1:0]      port_a_cs_code,
  input  wire logic [`BM_CS_W-1:0]      port_b_cs_code,
  input  wire logic                     port_a_clock_enable,
  input  wire logic                     port_a_write_enable,
  input  wire logic [`BM_CS_W-1:0]      port_a_chip_select,
  input  wire logic [`BM_ADDR_W-1:0]    port_a_address,
  input  wire logic [`BM_DATA_W-1:0]    port_a_write_data,
  input  wire logic                     port_a_output_reset,
  output logic [`BM_DATA_W-1:0]         port_a_read_data,
  input  wire logic                     port_b_clock_enable,
  input  wire logic                     port_b_write_enable,
  input  wire logic [`BM_CS_W-1:0]      port_b_chip_select,
  input  wire logic [`BM_ADDR_W-1:0]    port_b_address,
  input  wire logic [`BM_DATA_W-1:0]    port_b_write_data,
  input  wire logic                     port_b_output_reset,
  output logic [`BM_DATA_W-1:0]         port_b_read_data,
  input  wire logic                     write_clock_enable,
  input  wire logic                     write_enable,
  input  wire logic [`BM_CS_W-2:0]      write_chip_select,
  input  wire logic                     full_flag_input,
  input  wire logic [`BM_DATA_W-1:0]    fifo_write_data,
  input  wire logic                     read_clock_enable,
  input  wire logic                     read_enable,
  input  wire logic [`BM_CS_W-2:0]      read_chip_select,
  input  wire logic                     empty_flag_input,
  input  wire logic                     output_read_enable,
  input  wire logic [`BM_PTR_W-1:0]     almost_full_level,
  input  wire logic [`BM_PTR_W-1:0]     almost_empty_level,
  output logic                          full,
  output logic                          almost_full,
  output logic                          empty,
  output logic                          almost_empty,
  output logic                          read_request_ready,
  output logic                          fifo_read_valid,
  output logic [`BM_DATA_W-1:0]         fifo_read_data,
  input  wire logic                     fifo_read_ready
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Word width of a shape.
  function automatic logic [`BM_WIDTH_W-1:0] width_of(input shape_t sh);
    case (sh)
      shape_8192x1: width_of = `BM_WIDTH_W'd1;
      shape_4096x2: width_of = `BM_WIDTH_W'd2;
      shape_2048x4: width_of = `BM_WIDTH_W'd4;
      shape_1024x9: width_of = `BM_WIDTH_W'd9;
      default:      width_of = `BM_WIDTH_W'd18;
    endcase
  endfunction

  // Word count of a shape; all are powers of two.
  function automatic logic [`BM_PTR_W-1:0] depth_of(input shape_t sh);
    case (sh)
      shape_8192x1: depth_of = `BM_PTR_W'd8192;
      shape_4096x2: depth_of = `BM_PTR_W'd4096;
      shape_2048x4: depth_of = `BM_PTR_W'd2048;
      shape_1024x9: depth_of = `BM_PTR_W'd1024;
      default:      depth_of = `BM_PTR_W'd512;
    endcase
  endfunction

  // The widest shape is refused outside pseudo dual and FIFO modes.
  function automatic logic shape_ok(input mem_mode_t m, input shape_t sh);
    shape_ok = (sh != shape_512x18) || (m == mode_pseudo_dual) ||
               (m == mode_fifo);
  endfunction

  // First array bit of a word; the word index wraps at the depth.
  function automatic logic [`BM_PTR_W-1:0] bit_base(
    input logic [`BM_PTR_W-1:0] word,
    input shape_t               sh
  );
    logic [`BM_PTR_W-1:0] idx;
    logic [17:0]          prod;
    idx      = word & (depth_of(sh) - `BM_PTR_W'd1);
    prod     = {4'h0, idx} * {13'h0000, width_of(sh)};
    bit_base = prod[`BM_PTR_W-1:0];
  endfunction

  // Low bits set up to the word width.
  function automatic logic [`BM_DATA_W-1:0] width_mask(
    input logic [`BM_WIDTH_W-1:0] w
  );
    logic [`BM_DATA_W:0] one;
    one        = {{`BM_DATA_W{1'b0}}, 1'b1} << w;
    width_mask = `BM_DATA_W'(one - 19'h00001);
  endfunction

  // Gather one word from the array, least significant bit first.
  function automatic logic [`BM_DATA_W-1:0] read_word(
    input logic [`BM_MEM_BITS-1:0] m,
    input logic [`BM_PTR_W-1:0]    base,
    input logic [`BM_WIDTH_W-1:0]  w
  );
    logic [`BM_PTR_W-1:0] idx;
    read_word = `BM_DATA_RESET;
    for (int i = 0; i < `BM_DATA_W; i++) begin
      idx = base + `BM_PTR_W'(i);
      if ((`BM_WIDTH_W'(i) < w) && (idx < `BM_PTR_W'(`BM_MEM_BITS))) begin
        read_word[i] = m[idx];
      end
    end
  endfunction

  // Scatter one word into the array, least significant bit first.
  function automatic logic [`BM_MEM_BITS-1:0] write_word(
    input logic [`BM_MEM_BITS-1:0] m,
    input logic [`BM_PTR_W-1:0]    base,
    input logic [`BM_WIDTH_W-1:0]  w,
    input logic [`BM_DATA_W-1:0]   d
  );
    logic [`BM_PTR_W-1:0] idx;
    write_word = m;
    for (int i = 0; i < `BM_DATA_W; i++) begin
      idx = base + `BM_PTR_W'(i);
      if ((`BM_WIDTH_W'(i) < w) && (idx < `BM_PTR_W'(`BM_MEM_BITS))) begin
        write_word[idx] = d[i];
      end
    end
  endfunction

  // Output latch update for one port access.
  function automatic logic [`BM_DATA_W-1:0] next_latch(
    input logic [`BM_DATA_W-1:0]   cur,
    input port_req_t               r,
    input logic [`BM_WIDTH_W-1:0]  w,
    input write_mode_t             wm,
    input logic [`BM_MEM_BITS-1:0] m
  );
    next_latch = cur;
    if (r.valid && !r.we) begin
      next_latch = read_word(m, r.bit_addr, w);
    end else if (r.valid) begin
      case (wm)
        wm_write_through: next_latch = r.data & width_mask(w);
        wm_read_before_write: next_latch = read_word(m, r.bit_addr, w);
        default: next_latch = cur;
      endcase
    end
  endfunction

  // Threshold held inside the range that the depth allows.
  function automatic logic [`BM_PTR_W-1:0] clamp_level(
    input logic [`BM_PTR_W-1:0] lvl,
    input logic [`BM_PTR_W-1:0] depth
  );
    if (lvl == `BM_PTR_RESET) begin
      clamp_level = `BM_PTR_W'd1;
    end else if (lvl >= depth) begin
      clamp_level = depth - `BM_PTR_W'd1;
    end else begin
      clamp_level = lvl;
    end
  endfunction

  // ---------------------------------------------------------------
  // State and resets
  // ---------------------------------------------------------------
  core_state_t                s;
  core_state_t                next_s;
  logic [`BM_MEM_BITS-1:0]    mem;
  logic [`BM_MEM_BITS-1:0]    next_mem;
  logic [`BM_PTR_W-1:0]       rptr;
  logic [`BM_PTR_W-1:0]       next_rptr;
  logic                       core_rst_n;
  logic                       rptr_rst_n;
  logic                       buf_in_ready;
  logic [`BM_BUF_CNT_W-1:0]   buf_count;
  logic                       credit_ok;

  // Global reset and read-pointer reset work without the clock.
  assign core_rst_n = rstn && global_set_reset_n;
  assign rptr_rst_n = core_rst_n && !read_pointer_reset;

  // ---------------------------------------------------------------
  // Request capture, array access and flags
  // ---------------------------------------------------------------
  always_comb begin
    logic                   is_fifo;
    logic [`BM_WIDTH_W-1:0] w_a;
    logic [`BM_WIDTH_W-1:0] w_b;
    logic [`BM_PTR_W-1:0]   depth;
    logic [`BM_PTR_W-1:0]   count;
    logic [`BM_PTR_W-1:0]   ncount;
    logic                   fifo_wr;
    logic                   fifo_rd;
    logic [2:0]             inflight;
    next_s    = s;
    next_mem  = mem;
    next_rptr = rptr;
    ncount    = `BM_PTR_RESET;
    is_fifo   = memory_mode == mode_fifo;
    w_a       = width_of(port_a_cfg.shape);
    w_b       = is_fifo ? w_a : width_of(port_b_cfg.shape);
    depth     = depth_of(port_a_cfg.shape);
    count     = s.wptr - rptr;
    inflight  = {2'h0, is_fifo && s.req_b.valid} + {2'h0, s.push_pending};
    credit_ok = buf_in_ready &&
                (({1'b0, buf_count} + inflight) < 3'd`BM_BUF_DEPTH);
    fifo_wr   = is_fifo && write_enable && write_clock_enable &&
                ({full_flag_input, write_chip_select} == port_a_cs_code) &&
                (count != depth);
    fifo_rd   = is_fifo && read_enable && read_clock_enable &&
                ({empty_flag_input, read_chip_select} == port_b_cs_code) &&
                (count != `BM_PTR_RESET) && credit_ok;
    read_request_ready = is_fifo && (count != `BM_PTR_RESET) && credit_ok;
    // Input registers take address and data on the clock edge.
    if (is_fifo) begin
      next_s.req_a = '{fifo_wr, 1'b1, bit_base(s.wptr, port_a_cfg.shape),
                       fifo_write_data};
      next_s.req_b = '{fifo_rd, 1'b0, bit_base(rptr, port_a_cfg.shape),
                       `BM_DATA_RESET};
      next_s.wptr  = s.wptr + {13'h0000, fifo_wr};
      next_rptr    = rptr + {13'h0000, fifo_rd};
    end else begin
      next_s.req_a.valid = port_a_clock_enable &&
                           (port_a_chip_select == port_a_cs_code) &&
                           shape_ok(memory_mode, port_a_cfg.shape) &&
                           ((memory_mode != mode_pseudo_dual) ||
                            port_a_write_enable);
      next_s.req_a.we    = port_a_write_enable;
      next_s.req_a.bit_addr = bit_base({1'b0, port_a_address},
                                       port_a_cfg.shape);
      next_s.req_a.data  = port_a_write_data;
      next_s.req_b.valid = port_b_clock_enable &&
                           (port_b_chip_select == port_b_cs_code) &&
                           shape_ok(memory_mode, port_b_cfg.shape) &&
                           (memory_mode != mode_single);
      next_s.req_b.we    = port_b_write_enable &&
                           (memory_mode == mode_true_dual);
      next_s.req_b.bit_addr = bit_base({1'b0, port_b_address},
                                       port_b_cfg.shape);
      next_s.req_b.data  = port_b_write_data;
    end
    // Array stage works from the registered requests.
    next_s.latch_a = next_latch(s.latch_a, s.req_a, w_a,
                                port_a_cfg.write_mode, mem);
    next_s.latch_b = next_latch(s.latch_b, s.req_b, w_b,
                                port_b_cfg.write_mode, mem);
    if (s.req_a.valid && s.req_a.we) begin
      next_mem = write_word(next_mem, s.req_a.bit_addr, w_a, s.req_a.data);
    end
    if (s.req_b.valid && s.req_b.we) begin
      next_mem = write_word(next_mem, s.req_b.bit_addr, w_b, s.req_b.data);
    end
    next_s.push_pending = is_fifo && s.req_b.valid;
    // Output register stage adds one clock when selected.
    if (port_a_clock_enable) begin
      next_s.oreg_a = s.latch_a;
    end
    if (is_fifo ? output_read_enable : port_b_clock_enable) begin
      next_s.oreg_b = s.latch_b;
    end
    // Local output resets clear their own port only.
    if (port_a_output_reset) begin
      next_s.latch_a = `BM_DATA_RESET;
      next_s.oreg_a  = `BM_DATA_RESET;
    end
    if (port_b_output_reset) begin
      next_s.latch_b = `BM_DATA_RESET;
      next_s.oreg_b  = `BM_DATA_RESET;
    end
    // Flags from the pointers as they will stand after this edge.
    ncount              = next_s.wptr - next_rptr;
    next_s.full         = is_fifo && (ncount == depth);
    next_s.almost_full  = is_fifo &&
                          (ncount >= clamp_level(almost_full_level, depth));
    next_s.empty        = !is_fifo || (ncount == `BM_PTR_RESET);
    next_s.almost_empty = !is_fifo ||
                          (ncount <= clamp_level(almost_empty_level, depth));
  end

  // Control state; the global reset clears pointers, full flags, outputs and sets the empty flags.
  always_ff @(posedge mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      s              <= '0;
      s.empty        <= 1'b1;
      s.almost_empty <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Read pointer alone rewinds on its own reset for retransmission.
  always_ff @(posedge mclk or negedge rptr_rst_n) begin
    if (!rptr_rst_n) begin
      rptr <= `BM_PTR_RESET;
    end else begin
      rptr <= next_rptr;
    end
  end

  // Array contents load only at configuration reset, never at runtime.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem <= INIT_CONTENTS;
    end else begin
      mem <= next_mem;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Asynchronous local reset forces the port output at once.
  assign port_a_read_data =
    (output_reset_async && port_a_output_reset) ? `BM_DATA_RESET :
    (port_a_cfg.out_reg_en ? s.oreg_a : s.latch_a);
  assign port_b_read_data =
    (output_reset_async && port_b_output_reset) ? `BM_DATA_RESET :
    (port_b_cfg.out_reg_en ? s.oreg_b : s.latch_b);
  assign full         = s.full;
  assign almost_full  = s.almost_full;
  assign empty        = s.empty;
  assign almost_empty = s.almost_empty;

  // Popped words wait here so a stalled reader loses none.
  read_stall_buffer u_read_buffer (
    .mclk      (mclk),
    .rstn      (core_rst_n),
    .in_valid  (s.push_pending),
    .in_data   (s.latch_b),
    .in_ready  (buf_in_ready),
    .out_valid (fifo_read_valid),
    .out_data  (fifo_read_data),
    .out_ready (fifo_read_ready),
    .count     (buf_count)
  );

endmodule

`default_nettype wire

// File: testbench/fifo_flag_checker.sv
// Assertions on the FIFO flags and read stream of the block memory.
// Assumes a bind onto embedded_block_ram_fifo, all ports on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "block_memory_params.svh"
module fifo_flag_checker (
  input wire logic                  mclk,
  input wire logic                  rstn,
  input wire logic                  global_set_reset_n,
  input wire logic                  read_pointer_reset,
  input wire logic                  write_enable,
  input wire logic                  read_enable,
  input wire logic                  full,
  input wire logic                  almost_full,
  input wire logic                  empty,
  input wire logic                  almost_empty,
  input wire logic                  fifo_read_valid,
  input wire logic [`BM_DATA_W-1:0] fifo_read_data,
  input wire logic                  fifo_read_ready
);
  // ---------------------------------------------------------------
  // Flag and stream relations
  // ---------------------------------------------------------------
  // Every check runs on mclk; all but a_gsr rest while either reset is low, a_gsr only while rstn is.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn || !global_set_reset_n);
  property p_full; full |-> almost_full; endproperty
  a_full: assert property (p_full) else $error("full without almost");
  property p_empty; empty |-> almost_empty; endproperty
  a_empty: assert property (p_empty) else $error("empty without almost");
  property p_excl; !(full && empty); endproperty
  a_excl: assert property (p_excl) else $error("full and empty");
  property p_gsr;
    disable iff (!rstn)
    !global_set_reset_n |-> empty && almost_empty && !full && !almost_full
      && !fifo_read_valid;
  endproperty
  a_gsr: assert property (p_gsr) else $error("global reset missed");
  property p_hold;
    fifo_read_valid && !fifo_read_ready |=>
      fifo_read_valid && $stable(fifo_read_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word lost");
  property p_under;
    empty && !write_enable && !read_pointer_reset |=> empty;
  endproperty
  a_under: assert property (p_under) else $error("underrun");
  property p_over; full && !read_enable && !read_pointer_reset |=> full;
  endproperty
  a_over: assert property (p_over) else $error("overrun");
  property p_fall;
    $fell(empty) |-> $past(write_enable || read_pointer_reset);
  endproperty
  a_fall: assert property (p_fall) else $error("empty fell alone");
endmodule
bind embedded_block_ram_fifo fifo_flag_checker chk_i (.mclk, .rstn,
  .global_set_reset_n, .read_pointer_reset, .write_enable, .read_enable,
  .full, .almost_full, .empty, .almost_empty, .fifo_read_valid,
  .fifo_read_data, .fifo_read_ready);
`default_nettype wire

// File: testbench/read_sink.sv
// Consumer of the FIFO read stream that stalls when told to.
// Assumes stall changes just after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module read_sink (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic stall,
  output var logic  ready
);
  // Ready is registered so it only moves just after an edge.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ready <= 1'b0;
    else ready <= !stall;
  end
endmodule
`default_nettype wire

// File: testbench/test_embedded_block_ram_fifo.sv
// Self-checking bench for the block memory as a 1024 x 9 FIFO.
// Assumes the package, header and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "block_memory_params.svh"
module test_embedded_block_ram_fifo
  import block_memory_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0, rstn, global_set_reset_n, read_pointer_reset, stall;
  logic output_reset_async, port_a_clock_enable, port_a_write_enable;
  logic port_a_output_reset, port_b_clock_enable, port_b_write_enable;
  logic port_b_output_reset, write_clock_enable, write_enable;
  logic full_flag_input, read_clock_enable, read_enable, empty_flag_input;
  logic output_read_enable, fifo_read_ready, full, almost_full, empty;
  logic almost_empty, read_request_ready, fifo_read_valid;
  logic [2:0]  port_a_cs_code, port_b_cs_code;
  logic [2:0]  port_a_chip_select, port_b_chip_select;
  logic [1:0]  write_chip_select, read_chip_select;
  logic [12:0] port_a_address, port_b_address;
  logic [17:0] port_a_write_data, port_b_write_data, fifo_write_data;
  logic [17:0] port_a_read_data, port_b_read_data, fifo_read_data;
  logic [13:0] almost_full_level, almost_empty_level;
  logic [16:0] seed = 17'h14042;
  mem_mode_t   memory_mode;
  port_cfg_t   port_a_cfg, port_b_cfg;
  logic [17:0] exp_q[$], hist[$];
  int          fail_count, checks;
  logic [4:0]  flags;
  assign flags = {full, almost_full, empty, almost_empty, read_request_ready};
  embedded_block_ram_fifo DUT (.*);
  read_sink sink (.mclk(mclk), .rstn(rstn), .stall(stall),
    .ready(fifo_read_ready));
  // ---------------------------------------------------------------
  // Clock, random source, comparison and ending
  // ---------------------------------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  always #12.5 mclk = ~mclk;
  // The random word feeds both write data and the sink's stalls.
  always @(posedge mclk) begin
    seed <= lfsr(seed);
    stall <= seed[11];
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Each word leaving the stream is matched to the oldest note.
  always @(posedge mclk) begin
    if (fifo_read_valid === 1'b1 && fifo_read_ready === 1'b1)
      chk(fifo_read_data, exp_q.size() ? exp_q.pop_front() : 18'h3FFFF);
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  task automatic put(input int n, input bit keep);
    repeat (n) begin
      @(posedge mclk);
      write_enable <= 1'b1;
      fifo_write_data <= {9'h000, seed[8:0]};
      if (keep) exp_q.push_back({9'h000, seed[8:0]});
      if (keep) hist.push_back({9'h000, seed[8:0]});
    end
    @(posedge mclk);
    write_enable <= 1'b0;
    #1;
  endtask
  // Reads stay requested until empty, so reads when empty are tried.
  task automatic drain();
    @(posedge mclk);
    read_enable <= 1'b1;
    for (int i = 0; i < 8000 && empty !== 1'b1; i++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    read_enable <= 1'b0;
    repeat (30) @(posedge mclk);
    #1;
  endtask
  initial begin
    {rstn, read_pointer_reset, output_reset_async, port_a_clock_enable,
     port_a_write_enable, port_a_output_reset, port_b_clock_enable,
     port_b_write_enable, port_b_output_reset, write_clock_enable,
     write_enable, full_flag_input, read_clock_enable, read_enable,
     empty_flag_input, port_a_cs_code, port_b_cs_code, port_a_chip_select,
     port_b_chip_select, write_chip_select, read_chip_select,
     port_a_address, port_b_address, port_a_write_data, port_b_write_data,
     fifo_write_data} = '0;
    global_set_reset_n = 1'b1;
    output_read_enable = 1'b1;
    memory_mode = mode_fifo;
    port_a_cfg = '{shape_1024x9, wm_normal, 1'b0};
    port_b_cfg = '{shape_1024x9, wm_normal, 1'b1};
    almost_full_level = 14'h03FC;
    almost_empty_level = 14'h0004;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    write_clock_enable <= 1'b1;
    read_clock_enable <= 1'b1;
    #1 chk(flags, 18'h06);
    put(8, 1);
    chk(flags, 18'h01);
    drain();
    exp_q = hist;
    @(posedge mclk) read_pointer_reset <= 1'b1;
    @(posedge mclk) read_pointer_reset <= 1'b0;
    drain();
    put(3, 0);
    @(posedge mclk) global_set_reset_n <= 1'b0;
    @(posedge mclk) global_set_reset_n <= 1'b1;
    @(posedge mclk) #1;
    chk(flags, 18'h06);
    chk(port_b_read_data, 18'h0);
    @(posedge mclk) {full_flag_input, write_enable} <= 2'b11;
    @(posedge mclk) {full_flag_input, write_enable} <= 2'b00;
    @(posedge mclk) #1 chk(empty, 1'b1);
    put(1024, 1);
    chk(flags, 18'h19);
    put(1, 0);
    chk(flags, 18'h19);
    @(posedge mclk) {empty_flag_input, read_enable} <= 2'b11;
    @(posedge mclk) {empty_flag_input, read_enable} <= 2'b00;
    @(posedge mclk) #1 chk(flags, 18'h19);
    drain();
    chk(flags, 18'h06);
    chk(18'(exp_q.size()), 18'h0);
    chk(port_b_read_data, hist[$]);
    // Port A writes a word that port B reads back in true dual mode.
    @(posedge mclk) memory_mode <= mode_true_dual;
    {port_a_clock_enable, port_a_write_enable, port_b_clock_enable} <= 3'h7;
    {port_a_address, port_b_address} <= {2{13'h0005}};
    port_a_write_data <= 18'h00155;
    repeat (5) @(posedge mclk);
    #1 chk(port_b_read_data, 18'h00155);
    chk(port_a_read_data, 18'h0);
    @(posedge mclk) port_b_output_reset <= 1'b1;
    @(posedge mclk) #1 chk(port_b_read_data, 18'h0);
    test_done();
  end
endmodule
`default_nettype wire
